// ===== hw/tcr_pkg.sv
// package: register map, field layout and types of the tx/hw config block
package tcr_pkg;

    // =====================================================================
    // register map (byte addresses)
    localparam logic [7:0] TCR_TRANSMIT_CONFIG_OFS = 8'h70;
    localparam logic [7:0] TCR_HARDWARE_CONFIG_OFS = 8'h74;
    localparam logic [7:0] TCR_TX_STATUS_OFS = 8'h80;
    localparam int TCR_ADDR_W = 8;

    // =====================================================================
    // transmit_config fields
    localparam int TCR_TXC_STATUS_FLUSH_BIT = 15;
    localparam int TCR_TXC_DATA_FLUSH_BIT = 14;
    localparam int TCR_TXC_OVERRUN_ALLOW_BIT = 2;
    localparam int TCR_TXC_ENABLE_BIT = 1;
    localparam int TCR_TXC_STOP_BIT = 0;

    // =====================================================================
    // hardware_config fields
    localparam int TCR_HWC_CROSSOVER_BIT = 24;
    localparam int TCR_HWC_MUST_BE_ONE_BIT = 20;
    localparam int TCR_HWC_ALLOC_LSB = 16;
    localparam int TCR_HWC_ALLOC_W = 4;
    localparam int TCR_HWC_BUS_WIDTH_BIT = 2;
    localparam int TCR_HWC_TIMEOUT_BIT = 1;
    localparam int TCR_HWC_SOFT_RESET_BIT = 0;
    localparam logic [3:0] TCR_ALLOC_RESET = 4'h5;
    localparam logic [3:0] TCR_ALLOC_MIN = 4'h2;
    localparam logic [3:0] TCR_ALLOC_MAX = 4'hE;

    // =====================================================================
    // fifo memory split, bytes
    localparam logic [14:0] TCR_MEM_BYTES = 15'h4000;
    localparam logic [14:0] TCR_KB_BYTES = 15'h0400;
    localparam logic [14:0] TCR_TX_STATUS_BYTES = 15'h0200;

    // =====================================================================
    // soft reset time-out, in microseconds, and its cycle count
    localparam int TCR_CLK_MHZ = 50;
    localparam int TCR_SOFT_RESET_TIMEOUT_US = 100;
    localparam int TCR_SOFT_RESET_TIMEOUT_CYC = TCR_SOFT_RESET_TIMEOUT_US * TCR_CLK_MHZ;

    // =====================================================================
    // axi responses
    localparam logic [1:0] TCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] TCR_RESP_SLVERR = 2'h2;

    // =====================================================================
    // grouped signals
    typedef struct packed {
        logic [14:0] tx_data_bytes;
        logic [14:0] tx_status_bytes;
        logic [14:0] rx_total_bytes;
    } tcr_split_t;

    typedef struct packed {
        logic status_flush;
        logic data_flush;
        logic mac_reset;
        logic error_clear;
    } tcr_pulse_t;

    typedef enum logic [1:0] {
        TCR_TX_IDLE = 2'b00,
        TCR_TX_RUN = 2'b01,
        TCR_TX_STOPPING = 2'b10
    } tcr_tx_state_t;

endpackage : tcr_pkg

// ===== hw/tcr_sync2.sv
// module: two flip-flop synchroniser for asynchronous pin levels
module tcr_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end
endmodule : tcr_sync2

// ===== hw/tcr_fifo_split.sv
// module: turns the tx allocation into tx data, tx status and rx sizes
module tcr_fifo_split (
    // allocation
    input wire logic [3:0] alloc,
    // sizes
    output tcr_pkg::tcr_split_t split
);
    import tcr_pkg::*;

    logic [14:0] tx_total;

    always_comb
    begin
        tx_total = 15'(alloc * TCR_KB_BYTES);
        split.tx_status_bytes = TCR_TX_STATUS_BYTES;
        split.tx_data_bytes = 15'(tx_total - TCR_TX_STATUS_BYTES);
        split.rx_total_bytes = 15'(TCR_MEM_BYTES - tx_total);
    end
endmodule : tcr_fifo_split

// ===== hw/tcr_regs.sv
// module: transmit and hardware configuration registers on axi4-lite
module tcr_regs #(
    parameter int SOFT_RESET_TIMEOUT_CYC = tcr_pkg::TCR_SOFT_RESET_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // strap pins and phy state
    input wire logic crossover_strap_pin,
    input wire logic bus_width_strap_pin,
    input wire logic phy_clocks_running,
    input wire logic power_save_exit,
    // transmit engine
    input wire logic tx_status_full,
    input wire logic tx_frame_active,
    output logic tx_go,
    output logic tx_status_flush,
    output logic tx_data_flush,
    output logic tx_status_full_irq,
    // resets and fifo split
    output logic mac_reset,
    output logic error_clear,
    output logic [14:0] tx_data_bytes,
    output logic [14:0] rx_total_bytes
);
    import tcr_pkg::*;

    // the time-out counter is sixteen bits wide
    if (SOFT_RESET_TIMEOUT_CYC < 1 || SOFT_RESET_TIMEOUT_CYC > 65535)
    begin : g_timeout_range
        $error("SOFT_RESET_TIMEOUT_CYC out of range");
    end

    // =====================================================================
    // pin synchronisers
    logic [2:0] pins_s;
    tcr_sync2 #(.WIDTH(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({crossover_strap_pin, bus_width_strap_pin,
                   phy_clocks_running}),
        .sync_out(pins_s)
    );

    // =====================================================================
    // state
    logic aw_r, aw_nxt, w_r, w_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic armed_r, armed_nxt;
    logic allow_r, allow_nxt, enable_r, enable_nxt, stop_r, stop_nxt;
    logic mbo_r, mbo_nxt, timeout_r, timeout_nxt;
    logic [3:0] alloc_r, alloc_nxt;
    logic soft_reset_busy_r, soft_reset_busy_nxt;
    logic [15:0] soft_reset_cnt_r, soft_reset_cnt_nxt;
    logic [1:0] straps_r, straps_nxt;
    tcr_pulse_t pulse_r, pulse_nxt;
    tcr_tx_state_t txs_r, txs_nxt;
    logic go_r, go_nxt, full_irq_r, full_irq_nxt;
    logic [14:0] txd_bytes_r, rx_bytes_r;
    tcr_split_t split;

    tcr_fifo_split u_split (
        .alloc(alloc_r),
        .split(split)
    );

    function automatic logic [31:0] read_mux(input logic [7:0] a,
        input logic [31:0] txc, input logic [31:0] hwc);
        case (a)
            TCR_TRANSMIT_CONFIG_OFS: read_mux = txc;
            TCR_HARDWARE_CONFIG_OFS: read_mux = hwc;
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    // =====================================================================
    // bus and register next state
    logic do_wr, byte0, byte1, byte2, byte3, hit_w, hit_r;
    logic [31:0] txc_view, hwc_view;

    always_comb
    begin
        txc_view = 32'h0000_0000;
        txc_view[TCR_TXC_OVERRUN_ALLOW_BIT] = allow_r;
        txc_view[TCR_TXC_ENABLE_BIT] = enable_r;
        txc_view[TCR_TXC_STOP_BIT] = stop_r;
        hwc_view = 32'h0000_0000;
        hwc_view[TCR_HWC_CROSSOVER_BIT] = straps_r[1];
        hwc_view[TCR_HWC_MUST_BE_ONE_BIT] = mbo_r;
        hwc_view[TCR_HWC_ALLOC_LSB +: TCR_HWC_ALLOC_W] = alloc_r;
        hwc_view[TCR_HWC_BUS_WIDTH_BIT] = straps_r[0];
        hwc_view[TCR_HWC_TIMEOUT_BIT] = timeout_r;
        hwc_view[TCR_HWC_SOFT_RESET_BIT] = soft_reset_busy_r;

        aw_nxt = aw_r;
        w_nxt = w_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        if (awvalid && !aw_r)
        begin
            aw_nxt = 1'b1;
            awaddr_nxt = awaddr;
        end
        if (wvalid && !w_r)
        begin
            w_nxt = 1'b1;
            wdata_nxt = wdata;
            wstrb_nxt = wstrb;
        end
        do_wr = aw_r && w_r && !bvalid_r;
        bvalid_nxt = bvalid_r && !bready;
        bresp_nxt = bresp_r;
        hit_w = awaddr_r == TCR_TRANSMIT_CONFIG_OFS
            || awaddr_r == TCR_HARDWARE_CONFIG_OFS;
        if (do_wr)
        begin
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = hit_w ? TCR_RESP_OKAY : TCR_RESP_SLVERR;
        end
        byte0 = do_wr && armed_r && wstrb_r[0];
        byte1 = do_wr && armed_r && wstrb_r[1];
        byte2 = do_wr && armed_r && wstrb_r[2];
        byte3 = do_wr && armed_r && wstrb_r[3];

        rvalid_nxt = rvalid_r && !rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        armed_nxt = armed_r && !power_save_exit;
        if (arvalid && !rvalid_r)
        begin
            hit_r = araddr == TCR_TRANSMIT_CONFIG_OFS
                || araddr == TCR_HARDWARE_CONFIG_OFS;
            rvalid_nxt = 1'b1;
            rdata_nxt = read_mux(araddr, txc_view, hwc_view);
            rresp_nxt = hit_r ? TCR_RESP_OKAY : TCR_RESP_SLVERR;
            armed_nxt = 1'b1;
        end
        else
            hit_r = 1'b0;

        allow_nxt = allow_r;
        enable_nxt = enable_r;
        stop_nxt = stop_r;
        mbo_nxt = mbo_r;
        alloc_nxt = alloc_r;
        timeout_nxt = timeout_r;
        soft_reset_busy_nxt = soft_reset_busy_r;
        soft_reset_cnt_nxt = soft_reset_cnt_r;
        pulse_nxt = '0;
        straps_nxt = pins_s[2:1];
        txs_nxt = txs_r;

        if (awaddr_r == TCR_TRANSMIT_CONFIG_OFS)
        begin
            if (byte1)
            begin
                pulse_nxt.status_flush = wdata_r[TCR_TXC_STATUS_FLUSH_BIT];
                pulse_nxt.data_flush = wdata_r[TCR_TXC_DATA_FLUSH_BIT];
            end
            if (byte0)
            begin
                allow_nxt = wdata_r[TCR_TXC_OVERRUN_ALLOW_BIT];
                enable_nxt = wdata_r[TCR_TXC_ENABLE_BIT];
                if (!stop_r)
                    stop_nxt = wdata_r[TCR_TXC_STOP_BIT];
            end
        end
        if (awaddr_r == TCR_HARDWARE_CONFIG_OFS)
        begin
            if (byte2)
            begin
                mbo_nxt = wdata_r[TCR_HWC_MUST_BE_ONE_BIT];
                alloc_nxt = wdata_r[TCR_HWC_ALLOC_LSB +: TCR_HWC_ALLOC_W];
                if (alloc_nxt < TCR_ALLOC_MIN)
                    alloc_nxt = TCR_ALLOC_MIN;
                if (alloc_nxt > TCR_ALLOC_MAX)
                    alloc_nxt = TCR_ALLOC_MAX;
            end
            if (byte0 && wdata_r[TCR_HWC_SOFT_RESET_BIT] && !soft_reset_busy_r)
            begin
                soft_reset_busy_nxt = 1'b1;
                timeout_nxt = 1'b0;
                soft_reset_cnt_nxt = '0;
            end
        end

        // transmitter sequencing
        case (txs_r)
            TCR_TX_IDLE:
                if (enable_r && !stop_r)
                    txs_nxt = TCR_TX_RUN;
            TCR_TX_RUN:
                if (stop_r)
                    txs_nxt = TCR_TX_STOPPING;
                else if (!enable_r)
                    txs_nxt = TCR_TX_IDLE;
            TCR_TX_STOPPING:
                if (!tx_frame_active)
                begin
                    txs_nxt = TCR_TX_IDLE;
                    stop_nxt = 1'b0;
                    enable_nxt = 1'b0;
                end
            default: txs_nxt = TCR_TX_IDLE;
        endcase
        if (txs_r == TCR_TX_IDLE && stop_r)
        begin
            stop_nxt = 1'b0;
            enable_nxt = 1'b0;
        end

        // soft reset: completes once phy clocks run, else times out
        if (soft_reset_busy_r)
        begin
            if (pins_s[0])
            begin
                soft_reset_busy_nxt = 1'b0;
                pulse_nxt.mac_reset = 1'b1;
                pulse_nxt.error_clear = 1'b1;
                pulse_nxt.status_flush = 1'b1;
                pulse_nxt.data_flush = 1'b1;
                allow_nxt = 1'b0;
                enable_nxt = 1'b0;
                stop_nxt = 1'b0;
                alloc_nxt = TCR_ALLOC_RESET;
                mbo_nxt = 1'b0;
                txs_nxt = TCR_TX_IDLE;
            end
            else if (soft_reset_cnt_r == 16'(SOFT_RESET_TIMEOUT_CYC - 1))
            begin
                soft_reset_busy_nxt = 1'b0;
                timeout_nxt = 1'b1;
            end
            else
                soft_reset_cnt_nxt = 16'(soft_reset_cnt_r + 16'h0001);
        end

        go_nxt = (txs_nxt == TCR_TX_RUN || txs_nxt == TCR_TX_STOPPING)
            && (allow_nxt || !tx_status_full);
        full_irq_nxt = tx_status_full;
    end

    // =====================================================================
    // registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= TCR_RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= TCR_RESP_OKAY;
            armed_r <= 1'b0;
            allow_r <= 1'b0;
            enable_r <= 1'b0;
            stop_r <= 1'b0;
            mbo_r <= 1'b0;
            alloc_r <= TCR_ALLOC_RESET;
            timeout_r <= 1'b0;
            soft_reset_busy_r <= 1'b0;
            soft_reset_cnt_r <= '0;
            straps_r <= '0;
            pulse_r <= '0;
            txs_r <= TCR_TX_IDLE;
            go_r <= 1'b0;
            full_irq_r <= 1'b0;
            txd_bytes_r <= '0;
            rx_bytes_r <= '0;
        end
        else
        begin
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            armed_r <= armed_nxt;
            allow_r <= allow_nxt;
            enable_r <= enable_nxt;
            stop_r <= stop_nxt;
            mbo_r <= mbo_nxt;
            alloc_r <= alloc_nxt;
            timeout_r <= timeout_nxt;
            soft_reset_busy_r <= soft_reset_busy_nxt;
            soft_reset_cnt_r <= soft_reset_cnt_nxt;
            straps_r <= straps_nxt;
            pulse_r <= pulse_nxt;
            txs_r <= txs_nxt;
            go_r <= go_nxt;
            full_irq_r <= full_irq_nxt;
            txd_bytes_r <= split.tx_data_bytes;
            rx_bytes_r <= split.rx_total_bytes;
        end
    end

    // =====================================================================
    // outputs
    assign awready = !aw_r;
    assign wready = !w_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign tx_go = go_r;
    assign tx_status_flush = pulse_r.status_flush;
    assign tx_data_flush = pulse_r.data_flush;
    assign tx_status_full_irq = full_irq_r;
    assign mac_reset = pulse_r.mac_reset;
    assign error_clear = pulse_r.error_clear;
    assign tx_data_bytes = txd_bytes_r;
    assign rx_total_bytes = rx_bytes_r;
endmodule : tcr_regs

// ===== sim/tcr_regs_props.sv
// checker: port-level properties of the tx and hw config register block
module tcr_regs_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite
    input wire logic awvalid, awready, wvalid, wready, bvalid,
    input wire logic arvalid, arready, rvalid,
    input wire logic [7:0] awaddr,
    input wire logic [7:0] araddr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic [3:0] wstrb,
    input wire logic [1:0] bresp,
    input wire logic [1:0] rresp,
    // pins and transmit engine
    input wire logic crossover_strap_pin, bus_width_strap_pin,
    input wire logic power_save_exit, tx_status_full,
    input wire logic tx_status_flush, tx_data_flush, tx_status_full_irq,
    input wire logic mac_reset, error_clear,
    input wire logic [14:0] tx_data_bytes,
    input wire logic [14:0] rx_total_bytes
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ====================================================================
    // helpers: handshakes and the first-read arming of writes
    logic wr_hs, ar_hs, armed_r, armed_nxt;
    assign wr_hs = awvalid && awready && wvalid && wready;
    assign ar_hs = arvalid && arready;
    always_comb
    begin
        armed_nxt = armed_r;
        if (power_save_exit)
            armed_nxt = 1'b0;
        if (ar_hs)
            armed_nxt = 1'b1;
    end
    always_ff @(posedge aclk)
        armed_r <= aresetn ? armed_nxt : 1'b0;

    // ====================================================================
    // properties
    property p_status_flush;
        wr_hs && armed_r && awaddr == TCR_TRANSMIT_CONFIG_OFS && wstrb[1]
        && wdata[15] |-> ##2 tx_status_flush ##1 !tx_status_flush;
    endproperty
    a_status_flush: assert property (p_status_flush)
        else $error("status flush pulse missing");
    property p_data_flush;
        wr_hs && armed_r && awaddr == TCR_TRANSMIT_CONFIG_OFS && wstrb[1]
        && wdata[14] |-> ##2 tx_data_flush ##1 !tx_data_flush;
    endproperty
    a_data_flush: assert property (p_data_flush)
        else $error("data flush pulse missing");
    property p_wr_resp;
        wr_hs |-> ##2 bvalid && bresp == (($past(awaddr, 2) == 8'h70 ||
            $past(awaddr, 2) == 8'h74) ? TCR_RESP_OKAY : TCR_RESP_SLVERR);
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response wrong");
    property p_rd_answer;
        ar_hs |=> rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer late");
    property p_rd_unmapped;
        ar_hs && araddr != 8'h70 && araddr != 8'h74 |=>
            rdata == 32'h0000_0000 && rresp == TCR_RESP_SLVERR;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");
    property p_rd_reserved;
        ar_hs && araddr == 8'h70 |=> rdata[31:16] == 16'h0000
            && rdata[13:3] == 11'h000 && rresp == TCR_RESP_OKAY;
    endproperty
    a_rd_reserved: assert property (p_rd_reserved)
        else $error("reserved transmit bits not zero");
    property p_strap;
        ar_hs && araddr == 8'h74 && $stable(crossover_strap_pin)
        && $stable(bus_width_strap_pin) && $past(crossover_strap_pin, 4)
        == crossover_strap_pin && $past(bus_width_strap_pin, 4)
        == bus_width_strap_pin |=> rdata[31:25] == 7'h00
        && rdata[24] == $past(crossover_strap_pin)
        && rdata[2] == $past(bus_width_strap_pin);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap bits wrong");
    property p_sizes;
        $past(aresetn) |-> tx_data_bytes + TCR_TX_STATUS_BYTES
            + rx_total_bytes == TCR_MEM_BYTES && tx_data_bytes >= 15'h0600
            && tx_data_bytes <= 15'h3600;
    endproperty
    a_sizes: assert property (p_sizes)
        else $error("fifo split wrong");
    property p_irq;
        $past(aresetn) |-> tx_status_full_irq == $past(tx_status_full);
    endproperty
    a_irq: assert property (p_irq)
        else $error("full interrupt not following fifo");
    property p_mac_reset;
        $rose(mac_reset) |-> error_clear ##1 !mac_reset && !error_clear;
    endproperty
    a_mac_reset: assert property (p_mac_reset)
        else $error("soft reset pulses wrong");
endmodule : tcr_regs_props

// ===== sim/test_tx_and_hw_config_regs.sv
// testbench: register sequences for the tx and hw config block
module test_tx_and_hw_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;
    localparam int TO_CYC = 20;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tx_go;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic [3:0] wstrb = 4'h0, e;
    logic [1:0] bresp, rresp, resp;
    logic crossover_strap_pin = 1'b1, bus_width_strap_pin = 1'b1;
    logic phy_clocks_running = 1'b1, power_save_exit = 1'b0;
    logic tx_status_full = 1'b0, tx_frame_active = 1'b0;
    logic tx_status_flush, tx_data_flush, tx_status_full_irq;
    logic mac_reset, error_clear;
    logic [14:0] tx_data_bytes, rx_total_bytes;
    int fail_count = 0, check_count = 0, sf_n = 0, df_n = 0, mr_n = 0;
    int ec_n = 0;

    tcr_regs #(.SOFT_RESET_TIMEOUT_CYC(TO_CYC)) tcr_regs_i (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .crossover_strap_pin(crossover_strap_pin),
        .bus_width_strap_pin(bus_width_strap_pin),
        .phy_clocks_running(phy_clocks_running),
        .power_save_exit(power_save_exit),
        .tx_status_full(tx_status_full), .tx_frame_active(tx_frame_active),
        .tx_go(tx_go), .tx_status_flush(tx_status_flush),
        .tx_data_flush(tx_data_flush),
        .tx_status_full_irq(tx_status_full_irq),
        .mac_reset(mac_reset), .error_clear(error_clear),
        .tx_data_bytes(tx_data_bytes), .rx_total_bytes(rx_total_bytes)
    );

    initial
    begin
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        sf_n = sf_n + tx_status_flush;
        df_n = df_n + tx_data_flush;
        mr_n = mr_n + mac_reset;
        ec_n = ec_n + error_clear;
    end

    // ====================================================================
    // access tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        if (n >= 100) fail_count++;
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        if (n >= 100) fail_count++;
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        check(rd, exp);
    endtask : rc
    function automatic logic [31:0] hw(input logic [3:0] al,
        input logic must_be_one, xo, bw, to, sr);
        return {7'h00, xo, 3'h0, must_be_one, al, 13'h0000, bw, to, sr};
    endfunction : hw
    task automatic conclude();
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // ====================================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        wr(8'h70, 32'h0000_0006);
        check(resp, TCR_RESP_OKAY);
        rc(8'h70, 32'h0000_0000);
        rc(8'h74, hw(4'h5, 0, 1, 1, 0, 0));
        check(tx_go, 0);
        wr(8'h70, 32'h0000_0002);
        repeat (3) @(posedge aclk);
        check(tx_go, 1);
        tx_status_full <= 1'b1;
        repeat (3) @(posedge aclk);
        check(tx_go, 0);
        wr(8'h70, 32'h0000_0006);
        repeat (3) @(posedge aclk);
        check(tx_go, 1);
        check(tx_status_full_irq, 1);
        tx_status_full <= 1'b0;
        wr(8'h70, 32'hFFFF_3FFA);
        rc(8'h70, 32'h0000_0002);
        wr(8'h70, 32'h0000_C002);
        repeat (3) @(posedge aclk);
        rc(8'h70, 32'h0000_0002);
        check(sf_n, 1);
        check(df_n, 1);
        tx_frame_active <= 1'b1;
        wr(8'h70, 32'h0000_0003);
        wr(8'h70, 32'h0000_0002);
        rc(8'h70, 32'h0000_0003);
        tx_frame_active <= 1'b0;
        repeat (4) @(posedge aclk);
        rc(8'h70, 32'h0000_0000);
        check(tx_go, 0);
        power_save_exit <= 1'b1;
        @(posedge aclk);
        power_save_exit <= 1'b0;
        wr(8'h70, 32'h0000_0004);
        rc(8'h70, 32'h0000_0000);
        for (int a = 0; a < 16; a++)
        begin
            e = (a < 2) ? 4'h2 : (a > 14) ? 4'hE : 4'(a);
            wr(8'h74, 32'h0010_0000 | (a << 16));
            repeat (2) @(posedge aclk);
            check(tx_data_bytes, e * 1024 - 512);
            check(rx_total_bytes, 16384 - e * 1024);
            rc(8'h74, hw(e, 1, 1, 1, 0, 0));
        end
        wr(8'h74, 32'hFFFF_FFFE);
        rc(8'h74, hw(4'hE, 1, 1, 1, 0, 0));
        crossover_strap_pin <= 1'b0;
        bus_width_strap_pin <= 1'b0;
        phy_clocks_running <= 1'b0;
        wr(8'h70, 32'h0000_0004);
        repeat (4) @(posedge aclk);
        rc(8'h74, hw(4'hE, 1, 0, 0, 0, 0));
        wr(8'h74, 32'h001E_0001);
        rc(8'h74, hw(4'hE, 1, 0, 0, 0, 1));
        repeat (TO_CYC + 10) @(posedge aclk);
        rc(8'h74, hw(4'hE, 1, 0, 0, 1, 0));
        phy_clocks_running <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(8'h74, 32'h001E_0001);
        repeat (4) @(posedge aclk);
        rc(8'h74, hw(4'h5, 0, 0, 0, 0, 0));
        rc(8'h70, 32'h0000_0000);
        check(mr_n, 1);
        check(ec_n, 1);
        wr(8'h48, 32'h0000_0001);
        check(resp, TCR_RESP_SLVERR);
        rc(8'h48, 32'h0000_0000);
        check(resp, TCR_RESP_SLVERR);
        conclude();
    end

    // watchdog: the whole sequence needs well under this span
    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        conclude();
    end
endmodule : test_tx_and_hw_config_regs

bind tcr_regs tcr_regs_props tcr_regs_props_i (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .awaddr(awaddr), .araddr(araddr),
    .wdata(wdata), .rdata(rdata), .wstrb(wstrb), .bresp(bresp),
    .rresp(rresp), .crossover_strap_pin(crossover_strap_pin),
    .bus_width_strap_pin(bus_width_strap_pin),
    .power_save_exit(power_save_exit), .tx_status_full(tx_status_full),
    .tx_status_flush(tx_status_flush), .tx_data_flush(tx_data_flush),
    .tx_status_full_irq(tx_status_full_irq),
    .mac_reset(mac_reset), .error_clear(error_clear),
    .tx_data_bytes(tx_data_bytes), .rx_total_bytes(rx_total_bytes)
);
